// File: inc/bdm_map.vh
`ifndef BDM_MAP_VH
`define BDM_MAP_VH
// core register offsets within a bank
`define BDM_OFS_IND0 7'h00
`define BDM_OFS_IND1 7'h01
`define BDM_OFS_PCL 7'h02
`define BDM_OFS_STAT 7'h03
`define BDM_OFS_P0L 7'h04
`define BDM_OFS_P0H 7'h05
`define BDM_OFS_P1L 7'h06
`define BDM_OFS_P1H 7'h07
`define BDM_OFS_BSEL 7'h08
`define BDM_OFS_WORKING_REGISTER 7'h09
`define BDM_OFS_PROGRAM_COUNTER_LATCH_HIGH 7'h0A
`define BDM_OFS_INTC 7'h0B
// region limits within a bank
`define BDM_PER_FIRST 7'h0C
`define BDM_PER_LAST 7'h1F
`define BDM_GPR_FIRST 7'h20
`define BDM_GPR_LAST 7'h6F
`define BDM_COM_FIRST 7'h70
// sizes
`define BDM_BANKS 32
`define BDM_GPR_BYTES 80
`define BDM_COM_BYTES 16
`define BDM_GPR_TOTAL 2560
`define BDM_GPR_STRIDE 12'h050
// linear window and program-memory select in 16-bit pointer space
`define BDM_LIN_BASE 16'h2000
`define BDM_LIN_LIMIT 16'h29FF
`define BDM_PGM_BIT 15
// status bit positions and reset values
`define BDM_ST_C 0
`define BDM_ST_DC 1
`define BDM_ST_Z 2
`define BDM_ST_PD 3
`define BDM_ST_TO 4
`define BDM_BSEL_MASK 8'h1F
`define BDM_ZERO8 8'h00
`define BDM_ONE1 1'b1
`endif

// File: rtl/bdm_banked_memory.v
// Summary of operation
// RULE1: data space is 32 banks of 128 byte locations each
// RULE2: each bank holds up to 80 bytes general RAM after core and peripherals
// RULE3: 16 bytes common RAM reach the same storage in every bank
// RULE4: bank select register supplies bank number for direct accesses
// RULE5: unimplemented locations read as zero
// RULE6: every access resolves to one location of a 12-bit address
// RULE7: upper five address bits are bank, lower seven the offset
// RULE8: twelve core registers mirrored at offsets 00h to 0Bh in every bank
// RULE9: offsets 0Ch to 1Fh go to peripheral register space
// RULE10: any location reachable directly or through either file pointer
// RULE11: file pointers also see general RAM as one linear region
// RULE12: flag-updating instructions aimed at status block writes to Z, DC, C
// RULE13: software writes to watchdog expiry and power-down flags ignored
// RULE14: status bits 7 to 5 unimplemented and read as zero
// RULE15: bit 4 set by power-up, watchdog clear, sleep; cleared by time-out
// RULE16: bit 3 set by power-up and watchdog clear; cleared by sleep
// RULE17: zero flag set when the operation result is zero, else cleared
// RULE18: add/subtract set digit carry on carry out of bit 3
// RULE19: add/subtract set carry on carry out of bit 7
// RULE20: subtraction adds two's complement, carries read as inverted borrow
// RULE21: rotates load carry with bit shifted out of the source
// RULE22: por/brownout: expiry and power-down to one, arithmetic flags zero
// RULE23: pointer high bit 7 routes indirect reads to program memory low byte
// RULE24: common RAM sits at offsets 70h to 7Fh of each bank
// RULE25: core registers and common RAM identical in every bank
`include "bdm_map.vh"
module bdm_banked_memory (
  // clock, reset, enable
  input wire sys_clk,
  input wire arst_n,
  input wire clkEn,
  input wire porReset,
  // cpu access
  input wire accEn,
  input wire accWrite,
  input wire accIndirect,
  input wire accPtrSel,
  input wire [6:0] accOffset,
  input wire [7:0] accWdata,
  output reg [7:0] accRdata,
  output wire pgmReadReq,
  output wire [14:0] pgmAddr,
  input wire [13:0] pgmWord,
  // alu flag update
  input wire flagZUpd,
  input wire flagCarryUpd,
  input wire flagRotate,
  input wire [1:0] aluOp,
  input wire [7:0] aluA,
  input wire [7:0] aluB,
  input wire [7:0] logicResult,
  output reg [7:0] aluResult,
  // power and watchdog events
  input wire watchdogClearInstr,
  input wire sleepInstr,
  input wire watchdogTimeout,
  // peripheral register space
  output wire perSel,
  output wire perWrite,
  output wire [11:0] perAddr,
  output wire [7:0] perWdata,
  input wire [7:0] perRdata,
  // core register views
  output wire [7:0] pclOut,
  output wire [7:0] pclathOut,
  output wire [7:0] intconOut,
  output wire [7:0] wregOut,
  output wire [7:0] statusOut
);
  localparam ALU_ADD = 2'b00;
  localparam ALU_SUB = 2'b01;
  localparam ALU_RLF = 2'b10;
  localparam ALU_RRF = 2'b11;

  // ********************************************************
  // core registers
  // ********************************************************
  wire [7:0] pclQ, p0lQ, p0hQ, p1lQ, p1hQ, bselQ, wregQ, pclathQ, intconQ;
  reg flagCQ, flagDcQ, flagZQ, expiryQ, pdQ;
  reg [7:0] gprMem [0:`BDM_GPR_TOTAL-1];
  reg [7:0] comMem [0:`BDM_COM_BYTES-1];

  assign pclOut = pclQ;
  assign pclathOut = pclathQ;
  assign intconOut = intconQ;
  assign wregOut = wregQ;
  // RULE14: upper three bits are constant zero
  assign statusOut = {3'h0, expiryQ, pdQ, flagZQ, flagDcQ, flagCQ}; // RULE14

  // ********************************************************
  // address formation
  // ********************************************************
  wire [15:0] ptrVal = accPtrSel ? {p1hQ, p1lQ} : {p0hQ, p0lQ}; // RULE10
  wire ptrPgm = accIndirect & ptrVal[`BDM_PGM_BIT]; // RULE23
  wire ptrLin = accIndirect & ~ptrPgm &
    (ptrVal >= `BDM_LIN_BASE) & (ptrVal <= `BDM_LIN_LIMIT); // RULE11
  wire [15:0] linOfs = ptrVal - `BDM_LIN_BASE;
  // direct: bank from bank select; indirect: low 12 pointer bits
  wire [11:0] fullAddr = accIndirect ? ptrVal[11:0] :
    {bselQ[4:0], accOffset}; // RULE4 RULE6
  wire [4:0] bank = fullAddr[11:7]; // RULE7
  wire [6:0] ofs = fullAddr[6:0]; // RULE7
  wire isCore = ofs < `BDM_PER_FIRST; // RULE8 RULE25
  wire isPer = (ofs >= `BDM_PER_FIRST) & (ofs <= `BDM_PER_LAST); // RULE9
  wire isGpr = (ofs >= `BDM_GPR_FIRST) & (ofs <= `BDM_GPR_LAST); // RULE2
  wire isCom = ofs >= `BDM_COM_FIRST; // RULE3 RULE24
  // a bank's RAM is implemented only below the 2560-byte linear total
  wire [11:0] gprBanked = ({7'h00, bank} * `BDM_GPR_STRIDE) +
    {5'h00, ofs - `BDM_GPR_FIRST}; // RULE1 RULE2
  wire [11:0] gprIdx = ptrLin ? linOfs[11:0] : gprBanked;
  wire gprHit = ptrLin | (~ptrPgm & isGpr);
  wire [3:0] comIdx = ofs[3:0];

  wire acc = clkEn & accEn;
  wire wrEn = acc & accWrite & ~ptrPgm; // no program memory writes
  wire coreWr = wrEn & ~ptrLin & isCore;

  assign pgmReadReq = acc & ptrPgm & ~accWrite; // RULE23
  assign pgmAddr = ptrVal[14:0];
  assign perSel = acc & ~ptrPgm & ~ptrLin & isPer; // RULE9
  assign perWrite = perSel & accWrite;
  assign perAddr = fullAddr;
  assign perWdata = accWdata;

  // ********************************************************
  // read mux
  // ********************************************************
  always @* begin
    accRdata = `BDM_ZERO8; // RULE5
    if (ptrPgm) begin
      accRdata = pgmWord[7:0]; // RULE23
    end else if (ptrLin) begin
      accRdata = gprMem[gprIdx];
    end else if (isCore) begin
      case (ofs)
        // indirect ports read as zero whenever addressed, directly or through a pointer
        `BDM_OFS_IND0: accRdata = `BDM_ZERO8;
        `BDM_OFS_IND1: accRdata = `BDM_ZERO8;
        `BDM_OFS_PCL: accRdata = pclQ;
        `BDM_OFS_STAT: accRdata = statusOut;
        `BDM_OFS_P0L: accRdata = p0lQ;
        `BDM_OFS_P0H: accRdata = p0hQ;
        `BDM_OFS_P1L: accRdata = p1lQ;
        `BDM_OFS_P1H: accRdata = p1hQ;
        `BDM_OFS_BSEL: accRdata = bselQ & `BDM_BSEL_MASK;
        `BDM_OFS_WORKING_REGISTER: accRdata = wregQ;
        `BDM_OFS_PROGRAM_COUNTER_LATCH_HIGH: accRdata = pclathQ;
        `BDM_OFS_INTC: accRdata = intconQ;
        default: accRdata = `BDM_ZERO8; // RULE5
      endcase
    end else if (isPer) begin
      accRdata = perRdata;
    end else if (isGpr) begin
      accRdata = gprMem[gprIdx];
    end else if (isCom) begin
      accRdata = comMem[comIdx]; // RULE3
    end
  end

  // ********************************************************
  // alu flag computation
  // ********************************************************
  reg [8:0] sum;
  reg [4:0] nib;
  reg newC, newDc;
  always @* begin
    sum = 9'h000;
    nib = 5'h00;
    newC = flagCQ;
    newDc = flagDcQ;
    aluResult = logicResult;
    case (aluOp)
      ALU_ADD: begin
        sum = {1'b0, aluA} + {1'b0, aluB};
        nib = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]};
        aluResult = sum[7:0];
        newC = sum[8]; // RULE19
        newDc = nib[4]; // RULE18
      end
      ALU_SUB: begin
        // A minus B as A plus not B plus one: carry means no borrow
        sum = {1'b0, aluA} + {1'b0, ~aluB} + 9'h001; // RULE20
        nib = {1'b0, aluA[3:0]} + {1'b0, ~aluB[3:0]} + 5'h01; // RULE20
        aluResult = sum[7:0];
        newC = sum[8]; // RULE19
        newDc = nib[4]; // RULE18
      end
      ALU_RLF: begin
        aluResult = {aluA[6:0], flagCQ};
        newC = aluA[7]; // RULE21
      end
      ALU_RRF: begin
        aluResult = {flagCQ, aluA[7:1]};
        newC = aluA[0]; // RULE21
      end
      default: begin
        aluResult = logicResult;
      end
    endcase
  end

  // ********************************************************
  // register updates
  // ********************************************************
  // write strobes carry clkEn through coreWr, so a low enable freezes them
  bdm_data_reg #(.W(8)) pcl_u (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wrEn(coreWr & (ofs == `BDM_OFS_PCL)),
    .wrData(accWdata),
    .dataQ(pclQ)
  );

  bdm_data_reg #(.W(8)) p0l_u (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wrEn(coreWr & (ofs == `BDM_OFS_P0L)),
    .wrData(accWdata),
    .dataQ(p0lQ)
  );

  bdm_data_reg #(.W(8)) p0h_u (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wrEn(coreWr & (ofs == `BDM_OFS_P0H)),
    .wrData(accWdata),
    .dataQ(p0hQ)
  );

  bdm_data_reg #(.W(8)) p1l_u (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wrEn(coreWr & (ofs == `BDM_OFS_P1L)),
    .wrData(accWdata),
    .dataQ(p1lQ)
  );

  bdm_data_reg #(.W(8)) p1h_u (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wrEn(coreWr & (ofs == `BDM_OFS_P1H)),
    .wrData(accWdata),
    .dataQ(p1hQ)
  );

  // bank number keeps five bits; the rest reads back as zero
  bdm_data_reg #(.W(8)) bsel_u (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wrEn(coreWr & (ofs == `BDM_OFS_BSEL)),
    .wrData(accWdata & `BDM_BSEL_MASK), // RULE4
    .dataQ(bselQ)
  );

  bdm_data_reg #(.W(8)) working_register_u (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wrEn(coreWr & (ofs == `BDM_OFS_WORKING_REGISTER)),
    .wrData(accWdata),
    .dataQ(wregQ)
  );

  bdm_data_reg #(.W(8)) program_counter_latch_high_u (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wrEn(coreWr & (ofs == `BDM_OFS_PROGRAM_COUNTER_LATCH_HIGH)),
    .wrData(accWdata),
    .dataQ(pclathQ)
  );

  bdm_data_reg #(.W(8)) intc_u (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wrEn(coreWr & (ofs == `BDM_OFS_INTC)),
    .wrData(accWdata),
    .dataQ(intconQ)
  );

  // ********************************************************
  // status flags
  // ********************************************************
  wire statWr = coreWr & (ofs == `BDM_OFS_STAT);
  // any flag-updating instruction shields all three arithmetic bits
  wire flagWrBlock = flagZUpd | flagCarryUpd | flagRotate; // RULE12
  // logic operations hand their result in on a port of their own
  wire [7:0] zSrc = flagCarryUpd ? aluResult : logicResult; // RULE17
  reg flagCD, flagDcD, flagZD, expiryD, pdD;
  always @* begin
    flagCD = flagCQ;
    flagDcD = flagDcQ;
    flagZD = flagZQ;
    expiryD = expiryQ;
    pdD = pdQ;
    if (porReset) begin
      // power-on or brownout; the asynchronous reset arst_n also clears the arithmetic flags
      flagCD = 1'b0; // RULE22
      flagDcD = 1'b0; // RULE22
      flagZD = 1'b0; // RULE22
      expiryD = `BDM_ONE1; // RULE15 RULE22
      pdD = `BDM_ONE1; // RULE16 RULE22
    end else begin
      if (statWr & ~flagWrBlock) begin
        flagCD = accWdata[`BDM_ST_C]; // RULE12
        flagDcD = accWdata[`BDM_ST_DC]; // RULE12
        flagZD = accWdata[`BDM_ST_Z]; // RULE12
      end
      if (flagZUpd) begin
        flagZD = (zSrc == `BDM_ZERO8); // RULE17
      end
      if (flagCarryUpd) begin
        flagCD = newC; // RULE19
        flagDcD = newDc; // RULE18
      end else if (flagRotate) begin
        flagCD = newC; // RULE21
      end
      // expiry and power-down never take bus data
      if (watchdogTimeout) begin
        expiryD = 1'b0; // RULE13 RULE15
      end else if (watchdogClearInstr | sleepInstr) begin
        expiryD = 1'b1; // RULE15
      end
      if (sleepInstr) begin
        pdD = 1'b0; // RULE16
      end else if (watchdogClearInstr) begin
        pdD = 1'b1; // RULE16
      end
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flagCQ <= 1'b0; // RULE22
      flagDcQ <= 1'b0; // RULE22
      flagZQ <= 1'b0; // RULE22
      expiryQ <= `BDM_ONE1; // RULE22
      pdQ <= `BDM_ONE1; // RULE22
    end else if (clkEn) begin
      flagCQ <= flagCD;
      flagDcQ <= flagDcD;
      flagZQ <= flagZD;
      expiryQ <= expiryD;
      pdQ <= pdD;
    end
  end

  // ********************************************************
  // ram arrays, no reset
  // ********************************************************
  always @(posedge sys_clk) begin
    if (wrEn & gprHit & (gprIdx < `BDM_GPR_TOTAL))
      gprMem[gprIdx] <= accWdata; // RULE11
    if (wrEn & ~ptrLin & isCom)
      comMem[comIdx] <= accWdata; // RULE3 RULE25
  end
endmodule

// ********************************************************
// write-enabled register with asynchronous clear
// ********************************************************
module bdm_data_reg #(
  parameter W = 8
) (
  // clock and reset
  input wire sys_clk,
  input wire arst_n,
  // write port
  input wire wrEn,
  input wire [W-1:0] wrData,
  output reg [W-1:0] dataQ
);
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dataQ <= {W{1'b0}};
    end else if (wrEn) begin
      dataQ <= wrData;
    end
  end
endmodule

// File: tb/bdm_far_model.sv
module bdm_far_model (
  // program memory and peripheral answers
  input wire logic pgmReadReq,
  input wire logic [14:0] pgmAddr,
  input wire logic perSel,
  input wire logic [11:0] perAddr,
  output logic [13:0] pgmWord,
  output logic [7:0] perRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mv;
  logic [7:0] pv;
  assign mv = pgmAddr[7:0] ^ 8'hC3;
  assign pv = perAddr[7:0] ^ 8'h5A;
  // inverted when not asked, so stale data never matches
  assign pgmWord = pgmReadReq ? {6'h15, mv} : {6'h2A, ~mv};
  assign perRdata = perSel ? pv : ~pv;
endmodule

// File: tb/bdm_banked_memory_properties.sv
module bdm_banked_memory_chk (
  // clock and reset
  input wire sys_clk,
  input wire arst_n,
  // watched ports
  input wire clkEn,
  input wire porReset,
  input wire accEn,
  input wire accIndirect,
  input wire [6:0] accOffset,
  input wire [7:0] accRdata,
  input wire pgmReadReq,
  input wire [13:0] pgmWord,
  input wire perSel,
  input wire [11:0] perAddr,
  input wire flagZUpd,
  input wire flagCarryUpd,
  input wire [1:0] aluOp,
  input wire [7:0] aluA,
  input wire [7:0] aluB,
  input wire [7:0] aluResult,
  input wire [7:0] logicResult,
  input wire watchdogClearInstr,
  input wire sleepInstr,
  input wire watchdogTimeout,
  input wire [7:0] statusOut
);
  timeunit 1ns;
  timeprecision 1ps;
  wire anyEv;
  assign anyEv = clkEn & (watchdogClearInstr | sleepInstr |
                          watchdogTimeout | porReset);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  property p_hi;
    statusOut[7:5] == 3'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("status top bits set");
  property p_por;
    clkEn && porReset |=> statusOut == 8'h18;
  endproperty
  a_por: assert property (p_por) else $error("por value");
  property p_slp;
    clkEn && sleepInstr && !(watchdogTimeout || watchdogClearInstr ||
      porReset) |=> statusOut[4:3] == 2'b10;
  endproperty
  a_slp: assert property (p_slp) else $error("sleep flags");
  property p_keep;
    !anyEv |=> $stable(statusOut[4:3]);
  endproperty
  a_keep: assert property (p_keep) else $error("flags moved");
  property p_per;
    clkEn && accEn && !accIndirect && accOffset >= 7'h0C &&
      accOffset <= 7'h1F
      |-> perSel && perAddr[6:0] == accOffset;
  endproperty
  a_per: assert property (p_per) else $error("periph decode");
  property p_pgm;
    accEn && accIndirect && pgmReadReq |-> accRdata == pgmWord[7:0];
  endproperty
  a_pgm: assert property (p_pgm) else $error("pgm read");
  property p_c;
    clkEn && flagCarryUpd && aluOp == 2'h0 && !porReset |=> statusOut[0]
      == (({1'b0, $past(aluA)} + $past(aluB)) > 9'h0FF);
  endproperty
  a_c: assert property (p_c) else $error("carry");
  property p_z;
    clkEn && flagZUpd && flagCarryUpd && !aluOp[1] && !porReset
      |=> statusOut[2] == ($past(aluResult) == 8'h00);
  endproperty
  a_z: assert property (p_z) else $error("zero flag");
  property p_zl;
    clkEn && flagZUpd && !flagCarryUpd && !porReset
      |=> statusOut[2] == ($past(logicResult) == 8'h00);
  endproperty
  a_zl: assert property (p_zl) else $error("logic zero flag");
endmodule
bind bdm_banked_memory bdm_banked_memory_chk chk_u (.*);

// File: tb/test_banked_data_memory_status.sv
module test_banked_data_memory_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, arst_n = 1'b0, porReset = 1'b0, accEn = 1'b0;
  logic accWrite = 1'b0, accIndirect = 1'b0, accPtrSel = 1'b0;
  logic flagZUpd = 1'b0, flagCarryUpd = 1'b0, flagRotate = 1'b0;
  logic watchdogClearInstr = 1'b0, sleepInstr = 1'b0;
  logic watchdogTimeout = 1'b0;
  logic [6:0] accOffset = 7'h00;
  logic [7:0] accWdata = 8'h00, aluA = 8'h00, aluB = 8'h00, r;
  logic [1:0] aluOp = 2'h0;
  logic clkEn = 1'b1;
  logic [7:0] logicResult = 8'h00;
  wire [7:0] accRdata, aluResult, perRdata, statusOut, wregOut;
  wire [7:0] pclOut, pclathOut, intconOut;
  wire [13:0] pgmWord;
  wire [14:0] pgmAddr;
  wire [11:0] perAddr;
  wire pgmReadReq, perSel;
  int fails = 0, comparisons = 0, cnt = 0;
  bdm_banked_memory dut_u (.sys_clk, .arst_n, .clkEn, .porReset,
    .accEn, .accWrite, .accIndirect, .accPtrSel, .accOffset, .accWdata,
    .accRdata, .pgmReadReq, .pgmAddr, .pgmWord, .flagZUpd, .flagCarryUpd,
    .flagRotate, .aluOp, .aluA, .aluB, .logicResult, .aluResult,
    .watchdogClearInstr, .sleepInstr, .watchdogTimeout, .perSel,
    .perWrite(), .perAddr, .perWdata(), .perRdata, .pclOut, .pclathOut,
    .intconOut, .wregOut, .statusOut);
  bdm_far_model far_u (.pgmReadReq, .pgmAddr, .perSel, .perAddr,
    .pgmWord, .perRdata);
  // ****************
  // tasks
  // ****************
  task results;
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task acc(input logic w, i, p, input logic [6:0] o, input logic [7:0] d);
    {accEn, accWrite, accIndirect, accPtrSel} <= {1'b1, w, i, p};
    {accOffset, accWdata} <= {o, d};
    @(negedge sys_clk);
    r = accRdata;
    @(posedge sys_clk);
    accEn <= 1'b0;
    @(posedge sys_clk);
  endtask
  task wr(input logic [6:0] o, input logic [7:0] d);
    acc(1'b1, 1'b0, 1'b0, o, d);
  endtask
  task rdc(input logic [6:0] o, input logic [7:0] e);
    acc(1'b0, 1'b0, 1'b0, o, 8'h00);
    chk(r, e);
  endtask
  task ptr(input logic p, input logic [7:0] hi, lo);
    wr({5'h01, p, 1'b0}, lo);
    wr({5'h01, p, 1'b1}, hi);
  endtask
  // logic op with a status write in the same cycle
  task lz(input logic [7:0] v, input logic [7:0] st);
    logicResult <= v;
    {flagZUpd, accEn, accWrite, accIndirect} <= 4'hE;
    {accOffset, accWdata} <= {7'h03, 8'h07};
    @(posedge sys_clk);
    {flagZUpd, accEn} <= 2'h0;
    @(posedge sys_clk);
    chk(statusOut, st);
  endtask
  // event order: por, watchdog clear, sleep, timeout
  task ev(input logic [3:0] e, input logic [7:0] st);
    {porReset, watchdogClearInstr, sleepInstr, watchdogTimeout} <= e;
    @(posedge sys_clk);
    {porReset, watchdogClearInstr, sleepInstr, watchdogTimeout} <= 4'h0;
    @(posedge sys_clk);
    chk(statusOut, st);
  endtask
  task alu(input logic [1:0] op, input logic [7:0] a, b, input logic ws);
    {aluOp, aluA, aluB} <= {op, a, b};
    {flagZUpd, flagCarryUpd, flagRotate} <= {~op[1], ~op[1], op[1]};
    {accEn, accWrite, accIndirect} <= {ws, ws, 1'b0};
    {accOffset, accWdata} <= {7'h03, 8'h00};
    @(negedge sys_clk);
    r = aluResult;
    @(posedge sys_clk);
    {flagZUpd, flagCarryUpd, flagRotate, accEn} <= 4'h0;
    @(posedge sys_clk);
  endtask
  // ****************
  // scenarios
  // ****************
  task t_map;
    wr(7'h02, 8'h12);
    wr(7'h0A, 8'h34);
    wr(7'h0B, 8'h56);
    chk(pclOut, 8'h12);
    chk(pclathOut, 8'h34);
    chk(intconOut, 8'h56);
    wr(7'h09, 8'h55);
    wr(7'h08, 8'hFF);
    rdc(7'h08, 8'h1F);
    rdc(7'h09, 8'h55);
    wr(7'h08, 8'h00);
    wr(7'h70, 8'hA1);
    wr(7'h08, 8'h03);
    wr(7'h20, 8'h3C);
    rdc(7'h0C, 8'hD6);
    wr(7'h08, 8'h04);
    wr(7'h20, 8'h4D);
    rdc(7'h70, 8'hA1);
    rdc(7'h20, 8'h4D);
  endtask
  task t_ind;
    ptr(1'b0, 8'h01, 8'hA0);
    acc(1'b0, 1'b1, 1'b0, 7'h00, 8'h00);
    chk(r, 8'h3C);
    ptr(1'b1, 8'h21, 8'h40);
    acc(1'b1, 1'b1, 1'b1, 7'h00, 8'h77);
    rdc(7'h20, 8'h77);
    ptr(1'b0, 8'h00, 8'h00);
    acc(1'b0, 1'b1, 1'b0, 7'h00, 8'h00);
    chk(r, 8'h00);
    ptr(1'b1, 8'h83, 8'h45);
    acc(1'b0, 1'b1, 1'b1, 7'h00, 8'h00);
    chk(r, 8'h86);
  endtask
  task t_stat;
    wr(7'h03, 8'hFF);
    chk(statusOut, 8'h1F);
    wr(7'h03, 8'h00);
    ev(4'h2, 8'h10);
    ev(4'h1, 8'h00);
    ev(4'h4, 8'h18);
  endtask
  task t_alu;
    logic [15:0] cs [5] = '{16'h0F01, 16'hFF01, 16'h0505, 16'h0001,
                            16'h807F};
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] bb;
    logic op;
    logic [7:0] st;
    for (int i = 0; i < 5; i++) begin
      op = i > 1;
      bb = op ? ~cs[i][7:0] : cs[i][7:0];
      s = cs[i][15:8] + bb + op;
      h = cs[i][11:8] + bb[3:0] + op;
      alu({1'b0, op}, cs[i][15:8], cs[i][7:0], i == 4);
      chk(r, s[7:0]);
      st = {5'h03, s[7:0] == 8'h00, h[4], s[8]};
      chk(statusOut, st);
    end
    alu(2'h2, 8'h80, 8'h00, 1'b0);
    chk({7'h00, statusOut[0]}, 8'h01);
    alu(2'h3, 8'h80, 8'h00, 1'b0);
    chk({7'h00, statusOut[0]}, 8'h00);
    lz(8'h00, 8'h1C);
    lz(8'h5A, 8'h18);
    ev(4'h8, 8'h18);
  endtask
  // low enable must freeze registers and flags
  task t_en;
    clkEn <= 1'b0;
    wr(7'h09, 8'hAA);
    ev(4'h1, 8'h18);
    chk(wregOut, 8'h55);
    clkEn <= 1'b1;
  endtask
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cnt <= cnt + 1;
    // whole run needs well under a thousand cycles
    if (cnt == 5000) begin
      fails++;
      results;
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    chk(statusOut, 8'h18);
    t_map;
    t_ind;
    t_stat;
    t_alu;
    t_en;
    results;
  end
endmodule
